/* tx_buf_ctrl_map.vh */
// Purpose: Register map and encodings for the transmit buffer request control block
// Assumes: APB with 32-bit data, word-aligned registers
// Notes: Included by tx_buf_ctrl.v only
`ifndef TX_BUF_CTRL_MAP_VH
`define TX_BUF_CTRL_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_TX_BUFFER_CONTROL 12'h000
`define OFS_TX_BUFFER_STATUS 12'h004

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_TX_REQUEST 0
`define BIT_TX_ABORT 1
`define BIT_SINGLE_ATTEMPT 2
`define BIT_BUSY 2
`define RES_LSB 0
`define RES_MSB 1
`define CTRL_MSB 2

// ----------------------------------------
// Result encodings and reset values
// ----------------------------------------
`define RES_IN_PROGRESS 2'h0
`define RES_ABORTED 2'h1
`define RES_DONE_PLAIN 2'h2
`define RES_DONE_ABORT 2'h3
`define OPT_RESET 2'h0
`define CTRL_BUSY_SET 3'h2
`define ZERO_WORD 32'h0000_0000

`endif

/* tx_buf_ctrl.v */
// Purpose: Request and result logic of one CAN transmit buffer, APB slave for software
// Assumes: Protocol engine reports one-cycle outcome pulses while tx_pending is high
// Notes: Zero-wait APB slave; unmapped reads return zero, pslverr never set
`timescale 1ns/1ps
`include "tx_buf_ctrl_map.vh"

// What this block does
// - A plain request that completes sets the result to 10 and pulses tx-complete.
// - A plain request that loses arbitration or errors keeps result 00, no pulse, and retries.
// - A completion with abort pending gives result 11 and tx-complete, not abort.
// - With abort or single attempt pending, a loss or error stops, sets 01, pulses tx-abort.
// - Single attempt makes one try; success gives 10, or 11 if abort was also set.
// - The interrupt source is chosen from the engine outcome and the stop condition.
module tx_buf_ctrl
(
    input wire sys_clk, // 100 MHz clock
    input wire srst, // Synchronous reset, active high
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error, always low
    input wire tx_done, // Engine: frame sent, one-cycle pulse
    input wire tx_fail, // Engine: arbitration lost or error, one-cycle pulse
    output reg tx_pending, // Request outstanding to the engine
    output reg tx_single, // Engine: make one attempt only
    output reg tx_complete_irq, // One-cycle transmit-complete pulse
    output reg tx_abort_irq // One-cycle transmit-abort pulse
);

    // ----------------------------------------
    // Buffer states, one-hot
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_SEND = 2'h2;
    // Bits that software may still set while the frame is on its way
    localparam [`CTRL_MSB:0] BUSY_SET_MASK = `CTRL_BUSY_SET;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`CTRL_MSB:`BIT_TX_ABORT] opt_q;
    wire [`CTRL_MSB:`BIT_TX_ABORT] opt_d;
    reg [1:0] res_q;
    reg [1:0] res_d;
    wire cmp_d;
    wire abt_d;
    reg [31:0] rd_d;
    wire req_bit;
    wire abort_bit;
    wire single_bit;
    wire apb_setup;
    wire apb_access;
    wire wr_acc;
    wire rd_acc;
    wire ctrl_hit;
    wire stat_hit;
    wire ctrl_wr;
    wire stat_wr;
    wire new_req;
    wire add_abort;
    wire clr_res;
    wire ev_any;
    wire ev_done;
    wire ev_fail;
    wire ev_stop;
    wire ev_retry;
    wire ev_final;
    wire stop_armed;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Full compare: an alias would let a stray write land in the buffer
    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Code left by a frame that went out
    function [1:0] done_code;
        input abort_seen;
        begin
            if (abort_seen)
            begin
                done_code = `RES_DONE_ABORT;
            end
            else
            begin
                done_code = `RES_DONE_PLAIN;
            end
        end
    endfunction

    // ----------------------------------------
    // APB phases
    // ----------------------------------------
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign wr_acc = apb_access & pwrite;
    assign rd_acc = apb_setup & ~pwrite;
    assign ctrl_hit = hit(paddr, `OFS_TX_BUFFER_CONTROL);
    assign stat_hit = hit(paddr, `OFS_TX_BUFFER_STATUS);
    assign ctrl_wr = wr_acc & ctrl_hit;
    assign stat_wr = wr_acc & stat_hit;

    // ----------------------------------------
    // Request bits
    // ----------------------------------------
    assign req_bit = (state_q == ST_SEND);
    assign abort_bit = opt_q[`BIT_TX_ABORT];
    assign single_bit = opt_q[`BIT_SINGLE_ATTEMPT];

    // ----------------------------------------
    // Engine outcomes
    // ----------------------------------------
    // Pulses count only while a request is open; done wins over fail
    assign ev_any = req_bit & (tx_done | tx_fail);
    assign ev_done = req_bit & tx_done;
    assign ev_fail = req_bit & tx_fail & ~tx_done;
    assign stop_armed = abort_bit | single_bit;
    assign ev_stop = ev_fail & stop_armed;
    assign ev_retry = ev_fail & ~stop_armed;
    assign ev_final = ev_done | ev_stop;

    // ----------------------------------------
    // Software requests
    // ----------------------------------------
    // An idle write without the request bit is dropped
    assign new_req = ~req_bit & ctrl_wr & pwdata[`BIT_TX_REQUEST];
    // An outcome in the same cycle wins, so a late abort is lost
    assign add_abort = req_bit & ctrl_wr & ~ev_any;
    assign clr_res = ~req_bit & stat_wr;

    // ----------------------------------------
    // Buffer state machine
    // ----------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (new_req)
                begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (ev_final)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Abort and single attempt bits
    // ----------------------------------------
    // Loaded with a new request, cleared with the final result
    genvar i;
    generate
        for (i = `BIT_TX_ABORT; i <= `CTRL_MSB; i = i + 1)
        begin : g_opt
            assign opt_d[i] = ev_final ? 1'b0
                : new_req ? pwdata[i]
                : (add_abort & BUSY_SET_MASK[i] & pwdata[i]) ? 1'b1
                : opt_q[i];
        end
    endgenerate

    // ----------------------------------------
    // Transmission result
    // ----------------------------------------
    always @*
    begin
        res_d = res_q;
        if (ev_done)
        begin
            res_d = done_code(abort_bit);
        end
        else if (ev_stop)
        begin
            res_d = `RES_ABORTED;
        end
        else if (ev_retry)
        begin
            res_d = `RES_IN_PROGRESS;
        end
        else if (new_req | clr_res)
        begin
            res_d = `RES_IN_PROGRESS;
        end
    end

    // ----------------------------------------
    // Interrupt source
    // ----------------------------------------
    // A pending abort changes only the code; the source stays tx-complete
    assign cmp_d = ev_done;
    assign abt_d = ev_stop;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @*
    begin
        rd_d = `ZERO_WORD;
        if (ctrl_hit)
        begin
            rd_d[`BIT_TX_REQUEST] = req_bit;
            rd_d[`CTRL_MSB:`BIT_TX_ABORT] = opt_q;
        end
        else if (stat_hit)
        begin
            rd_d[`RES_MSB:`RES_LSB] = res_q;
            rd_d[`BIT_BUSY] = req_bit;
        end
    end

    // ----------------------------------------
    // Control and result registers
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            opt_q <= `OPT_RESET;
            res_q <= `RES_IN_PROGRESS;
        end
        else
        begin
            state_q <= state_d;
            opt_q <= opt_d;
            res_q <= res_d;
        end
    end

    // ----------------------------------------
    // APB response
    // ----------------------------------------
    // Zero wait: ready follows every setup cycle, so a master never stalls
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata <= `ZERO_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            // Captured at setup so the word stands through the access phase
            if (rd_acc)
            begin
                prdata <= rd_d;
            end
        end
    end

    // ----------------------------------------
    // Engine side
    // ----------------------------------------
    // Taken from next values so these change together with the state
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            tx_pending <= 1'b0;
            tx_single <= 1'b0;
        end
        else
        begin
            tx_pending <= (state_d == ST_SEND);
            tx_single <= opt_d[`BIT_SINGLE_ATTEMPT];
        end
    end

    // ----------------------------------------
    // Interrupt pulses
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            tx_complete_irq <= 1'b0;
            tx_abort_irq <= 1'b0;
        end
        else
        begin
            tx_complete_irq <= cmp_d;
            tx_abort_irq <= abt_d;
        end
    end

endmodule // tx_buf_ctrl

/* tx_buf_ctrl_asserts.sv */
// Purpose: Port assertions for the transmit buffer request control
// Assumes: One clock domain, bound to tx_buf_ctrl
// Notes: Abort bit is not a port, so it is inferred from tx_pending
`timescale 1ns/1ps
module tx_buf_ctrl_asserts
(
    input wire sys_clk, // Clock
    input wire srst, // Reset
    input wire psel, // Select
    input wire penable, // Enable
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire tx_done, // Sent
    input wire tx_fail, // Lost
    input wire tx_pending, // Open
    input wire tx_single, // One try
    input wire tx_complete_irq, // Done pulse
    input wire tx_abort_irq // Abort pulse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    done_report_a:
        assert property (tx_pending && tx_done |=> tx_complete_irq && !tx_abort_irq)
        else $error("done not reported");
    fail_route_a:
        assert property (tx_pending && tx_fail && !tx_done |=>
            !tx_complete_irq && (tx_abort_irq != tx_pending)) else $error("bad fail route");
    single_stop_a:
        assert property (tx_pending && tx_single && tx_fail && !tx_done |=> tx_abort_irq)
        else $error("single not stopped");
    buffer_free_a:
        assert property (tx_pending && tx_done |=> !tx_pending && !tx_single)
        else $error("buffer not freed");
    done_cause_a:
        assert property (tx_complete_irq |-> $past(tx_pending && tx_done))
        else $error("done pulse uncaused");
    abort_cause_a:
        assert property (tx_abort_irq |-> $past(tx_pending && tx_fail && !tx_done))
        else $error("abort pulse uncaused");
    apb_ready_a: assert property (psel && !penable |=> pready && !pslverr)
        else $error("no ready");
endmodule // tx_buf_ctrl_asserts

/* tx_engine_model.sv */
// Purpose: Engine stand-in reporting frame outcomes
// Assumes: plan 1 sends, 2 fails, 0 holds the frame back
// Notes: Pulses only while a request is open
`timescale 1ns/1ps
module tx_engine_model
(
    input wire sys_clk, // Clock
    input wire srst, // Reset
    input wire tx_pending, // Open
    input wire [1:0] plan, // Outcome
    output reg tx_done = 1'b0, // Sent
    output reg tx_fail = 1'b0 // Lost
);
    // Gap after a pulse so the buffer drops its request first
    always @(posedge sys_clk)
    begin
        tx_done <= 1'b0;
        tx_fail <= 1'b0;
        if (!srst && tx_pending && !tx_done && !tx_fail)
        begin
            tx_done <= plan == 2'h1;
            tx_fail <= plan == 2'h2;
        end
    end
endmodule // tx_engine_model

/* tx_buf_ctrl_tb.sv */
// Purpose: Self-checking bench for the transmit buffer request control
// Assumes: Zero-wait APB slave, engine stand-in on the far side
// Notes: Every request combination with both outcomes
`timescale 1ns/1ps
module tx_buf_ctrl_tb;
    logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, a, s, f;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rq[$], iq[$];
    logic [15:0] rnd = 16'hD503;
    logic [1:0] plan = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, tx_done, tx_fail, tx_pending, tx_single, tx_complete_irq, tx_abort_irq;
    int errors = 0, checks = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    tx_buf_ctrl dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_done, .tx_fail, .tx_pending, .tx_single, .tx_complete_irq,
        .tx_abort_irq);
    tx_engine_model eng (.sys_clk, .srst, .tx_pending, .plan, .tx_done, .tx_fail);
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reads carry their expected word in d
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        if (!w)
            rq.push_back(d);
        // One idle edge first, so psel is never dropped and raised in one step
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk) penable <= 1'b1;
        @(posedge sys_clk);
        while (!pready) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
        if (psel && penable && pready && !pwrite)
            cmp("read", rq.pop_front(), prdata);
        if (tx_complete_irq || tx_abort_irq)
            cmp("irq", iq.pop_front(), {30'h0, tx_abort_irq, tx_complete_irq});
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            {f, s, a} = i[2:0];
            rnd = lfsr(rnd);
            plan <= f ? 2'h2 : 2'h1;
            iq.push_back((f && (a || s)) ? 32'h2 : 32'h1);
            apb(1'b1, 12'h000, {rnd, 13'h0, s, a, 1'b1});
            if (f && !(a || s))
            begin
                repeat (6) @(posedge sys_clk);
                apb(1'b0, 12'h004, 32'h4);
                apb(1'b0, 12'h000, 32'h1);
                plan <= 2'h1;
            end
            repeat (2) @(posedge sys_clk);
            while (tx_pending) @(posedge sys_clk);
            plan <= 2'h0;
            apb(1'b0, 12'h004, {30'h0, (f && (a || s)) ? 2'h1 : (a ? 2'h3 : 2'h2)});
            $display("case %0d done", i);
        end
        // Idle status write returns the result to in progress; control stays free
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        $display("clear done");
        close_out();
    end
endmodule // tx_buf_ctrl_tb
bind tx_buf_ctrl tx_buf_ctrl_asserts chk (.sys_clk, .srst, .psel, .penable, .pready, .pslverr,
    .tx_done, .tx_fail, .tx_pending, .tx_single, .tx_complete_irq, .tx_abort_irq);
